// *** rtl/gp_timer_pkg.sv ***
package gp_timer_pkg;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [11:0] OFS_CFG      = 12'h000;
	localparam logic [11:0] OFS_AMODE    = 12'h004;
	localparam logic [11:0] OFS_BMODE    = 12'h008;
	localparam logic [11:0] OFS_CTL      = 12'h00c;
	localparam logic [11:0] OFS_IMASK    = 12'h018;
	localparam logic [11:0] OFS_RAWSTAT  = 12'h01c;
	localparam logic [11:0] OFS_MSKSTAT  = 12'h020;
	localparam logic [11:0] OFS_ICLEAR   = 12'h024;
	localparam logic [11:0] OFS_ALOAD    = 12'h028;
	localparam logic [11:0] OFS_BLOAD    = 12'h02c;
	localparam logic [11:0] OFS_AMATCH   = 12'h030;
	localparam logic [11:0] OFS_BMATCH   = 12'h034;
	localparam logic [11:0] OFS_APRESC   = 12'h038;
	localparam logic [11:0] OFS_BPRESC   = 12'h03c;
	localparam logic [11:0] OFS_ACOUNT   = 12'h048;
	localparam logic [11:0] OFS_BCOUNT   = 12'h04c;

	// ****************************************
	// Configuration values
	// ****************************************
	localparam logic [2:0] CFG_32_TIMER = 3'h0;
	localparam logic [2:0] CFG_32_RTC   = 3'h1;
	localparam logic [2:0] CFG_16_SPLIT = 3'h4;

	typedef enum logic [1:0] {
		HALF_NONE     = 2'h0,
		HALF_ONESHOT  = 2'h1,
		HALF_PERIODIC = 2'h2,
		HALF_CAPTURE  = 2'h3
	} halfmode_t;

	typedef enum logic [1:0] {
		EDGE_RISE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_BOTH = 2'h3
	} edgesel_t;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int MODE_CAPTIME = 2;
	localparam int MODE_PWM     = 3;
	localparam int CTL_EN       = 0;
	localparam int CTL_STALL    = 1;
	localparam int CTL_EDGE     = 2;
	localparam int CTL_RTCEN    = 4;
	localparam int CTL_TRIGEN   = 5;
	localparam int CTL_PWMINV   = 6;
	localparam int CTL_B_OFS    = 8;
	localparam int ST_TIMEOUT   = 0;
	localparam int ST_CAPMATCH  = 1;
	localparam int ST_CAPEVENT  = 2;
	localparam int ST_RTC       = 3;
	localparam int ST_B_OFS     = 8;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [15:0] CNT_RESET      = 16'hffff;
	localparam logic [15:0] LOAD_RESET     = 16'hffff;
	localparam logic [7:0]  PRESCALE_RESET = 8'h00;
	localparam logic [31:0] RTC_FIRST_LOAD = 32'h00000001;
	localparam int          RTC_CLOCK_HZ   = 32768;
	localparam logic [14:0] RTC_DIV_LAST   = 15'(RTC_CLOCK_HZ - 1);

endpackage

// *** rtl/timer_half_if.sv ***
`timescale 1ns/1ns
interface timer_half_if;
	logic        enable;
	logic        stall;
	logic        loadWrite;
	logic        pin;
	logic        pwmInvert;
	logic        capTimeMode;
	logic        pwmMode;
	logic [1:0]  mode;
	logic [1:0]  edgeSel;
	logic [15:0] loadVal;
	logic [15:0] matchVal;
	logic [7:0]  prescale;
	logic [15:0] count;
	logic [15:0] capValue;
	logic        timeout;
	logic        capMatch;
	logic        capEvent;
	logic        clearEnable;
	logic        pwmOut;
	logic        pwmDrive;

	modport ctrl (
		output enable, stall, loadWrite, pin, pwmInvert, capTimeMode, pwmMode, mode, edgeSel,
		output loadVal, matchVal, prescale,
		input  count, capValue, timeout, capMatch, capEvent, clearEnable, pwmOut, pwmDrive
	);
	modport half (
		input  enable, stall, loadWrite, pin, pwmInvert, capTimeMode, pwmMode, mode, edgeSel,
		input  loadVal, matchVal, prescale,
		output count, capValue, timeout, capMatch, capEvent, clearEnable, pwmOut, pwmDrive
	);
endinterface

// *** rtl/timer_half.sv ***
`timescale 1ns/1ns
module timer_half
	import gp_timer_pkg::*;
(
	input wire logic   core_clk,
	input wire logic   reset_n,
	timer_half_if.half hb
);
	logic        pinPrevQ;
	logic [7:0]  preQ;
	logic [15:0] cntQ;
	logic [15:0] capQ;
	logic        pwmQ;
	logic        driveQ;
	logic        timerMode;
	logic        edgeCount;
	logic        edgeTime;
	logic        pwmMode;
	logic        tick;
	logic        step;
	logic        zero;
	logic        edgeHit;
	logic        rise;
	logic        fall;
	logic [15:0] cntNext;

	always_comb begin
		rise      = hb.pin && !pinPrevQ;
		fall      = !hb.pin && pinPrevQ;
		timerMode = !hb.pwmMode && (hb.mode == HALF_ONESHOT || hb.mode == HALF_PERIODIC);
		edgeCount = !hb.pwmMode && hb.mode == HALF_CAPTURE && !hb.capTimeMode;
		edgeTime  = !hb.pwmMode && hb.mode == HALF_CAPTURE && hb.capTimeMode;
		pwmMode   = hb.pwmMode && hb.mode != HALF_NONE;
		tick      = hb.enable && !hb.stall;
		zero      = cntQ == 16'h0000;
		cntNext   = cntQ - 16'h0001;
		unique case (hb.edgeSel)
			EDGE_RISE: edgeHit = rise;
			EDGE_FALL: edgeHit = fall;
			default:   edgeHit = rise || fall;
		endcase
		// Prescaler only gates the one-shot and periodic count
		if (timerMode) begin
			step = tick && preQ == 8'h00;
		end else if (edgeCount) begin
			step = tick && edgeHit;
		end else begin
			step = tick && (edgeTime || pwmMode);
		end
	end

	assign hb.timeout     = step && zero && timerMode;
	assign hb.capMatch    = step && edgeCount && cntNext == hb.matchVal;
	assign hb.capEvent    = tick && edgeTime && edgeHit;
	assign hb.clearEnable = hb.capMatch || (hb.timeout && hb.mode == HALF_ONESHOT);
	assign hb.count       = cntQ;
	assign hb.capValue    = capQ;
	assign hb.pwmOut      = pwmQ;
	assign hb.pwmDrive    = driveQ;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cntQ <= CNT_RESET;
		end else if (hb.loadWrite) begin
			cntQ <= hb.loadVal;
		end else if (step) begin
			if (edgeCount ? hb.capMatch : zero) begin
				cntQ <= hb.loadVal;
			end else begin
				cntQ <= cntNext;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			preQ <= PRESCALE_RESET;
		end else if (!timerMode || !hb.enable || hb.loadWrite) begin
			preQ <= hb.prescale;
		end else if (tick) begin
			preQ <= (preQ == 8'h00) ? hb.prescale : preQ - 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			capQ     <= CNT_RESET;
			pinPrevQ <= 1'b0;
		end else begin
			pinPrevQ <= hb.pin;
			if (hb.capEvent) begin
				capQ <= cntQ;
			end
		end
	end

	// Output idles low when the half is not producing PWM
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pwmQ   <= 1'b0;
			driveQ <= 1'b0;
		end else begin
			driveQ <= pwmMode && hb.enable;
			pwmQ   <= (pwmMode && hb.enable) ? ((cntQ > hb.matchVal) ^ hb.pwmInvert) : 1'b0;
		end
	end
endmodule

// *** rtl/general_timer_module.sv ***
`timescale 1ns/1ns
module general_timer_module
	import gp_timer_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	input  wire logic        capturePinZeroIn,
	output      logic        capturePinZeroOut,
	output      logic        capturePinZeroOe,
	input  wire logic        capturePinOneIn,
	output      logic        capturePinOneOut,
	output      logic        capturePinOneOe,
	input  wire logic        debugHalt,
	input  wire logic        adcTriggerChainIn,
	output      logic        adcTrigger,
	output      logic        timerIrq
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [2:0]  cfgQ;
	logic [3:0]  amodeQ;
	logic [3:0]  bmodeQ;
	logic [15:0] ctlQ;
	logic [10:0] imaskQ;
	logic [10:0] rawQ;
	logic [15:0] aloadQ;
	logic [15:0] bloadQ;
	logic [15:0] amatchQ;
	logic [15:0] bmatchQ;
	logic [7:0]  aprescQ;
	logic [7:0]  bprescQ;
	logic [31:0] cnt32Q;
	logic [14:0] rtcDivQ;
	logic        rtcPrevQ;
	logic        aLoadPulseQ;
	logic        bLoadPulseQ;
	logic        reload32Q;
	logic [31:0] prdataQ;
	logic        preadyQ;
	logic        pslverrQ;
	logic        irqQ;
	logic        adcQ;
	logic [1:0]  pinOutQ;
	logic [1:0]  pinOeQ;
	logic [2:0]  syncQ [2];
	logic [1:0]  pinQ;
	logic        access;
	logic        wrEn;
	logic        hit;
	logic [31:0] rdata;
	logic        mode32;
	logic        modeRtc;
	logic        split;
	logic        run32;
	logic        secTick;
	logic        to32Evt;
	logic        rtcEvt;
	logic        rtcStart;
	logic        clrA;
	logic        clrB;
	logic [10:0] setBits;
	logic [10:0] clrBits;
	logic [31:0] matchCat;
	logic [31:0] loadCat;
	logic [1:0]  pinRaw;

	timer_half_if ha ();
	timer_half_if hb ();

	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	assign pinRaw = {capturePinOneIn, capturePinZeroIn};

	// A level counts only once the second and third stages agree
	for (genvar p = 0; p < 2; p++) begin : g_pin
		always_ff @(posedge core_clk or negedge reset_n) begin
			if (!reset_n) begin
				syncQ[p] <= 3'h0;
				pinQ[p]  <= 1'b0;
			end else begin
				syncQ[p] <= {syncQ[p][1:0], pinRaw[p]};
				if (syncQ[p][1] == syncQ[p][2]) begin
					pinQ[p] <= syncQ[p][2];
				end
			end
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	// One wait state so read data and pready both leave flip-flops
	assign access = psel && penable;
	assign wrEn   = access && preadyQ && pwrite;

	always_comb begin
		hit   = paddr[1:0] == 2'b00;
		rdata = 32'h0000_0000;
		unique case (paddr)
			OFS_CFG:     rdata = {29'h0, cfgQ};
			OFS_AMODE:   rdata = {28'h0, amodeQ};
			OFS_BMODE:   rdata = {28'h0, bmodeQ};
			OFS_CTL:     rdata = {16'h0, ctlQ};
			OFS_IMASK:   rdata = {21'h0, imaskQ};
			OFS_RAWSTAT: rdata = {21'h0, rawQ};
			OFS_MSKSTAT: rdata = {21'h0, rawQ & imaskQ};
			OFS_ICLEAR:  rdata = 32'h0000_0000;
			OFS_ALOAD:   rdata = split ? {16'h0, aloadQ} : loadCat;
			OFS_BLOAD:   rdata = {16'h0, bloadQ};
			OFS_AMATCH:  rdata = split ? {16'h0, amatchQ} : matchCat;
			OFS_BMATCH:  rdata = {16'h0, bmatchQ};
			OFS_APRESC:  rdata = {24'h0, aprescQ};
			OFS_BPRESC:  rdata = {24'h0, bprescQ};
			OFS_ACOUNT:  rdata = split ? {16'h0, (ha.capTimeMode ? ha.capValue : ha.count)} : cnt32Q;
			OFS_BCOUNT:  rdata = split ? {16'h0, (hb.capTimeMode ? hb.capValue : hb.count)}
				: {16'h0, cnt32Q[31:16]};
			default:     hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			preadyQ  <= 1'b0;
			pslverrQ <= 1'b0;
			prdataQ  <= 32'h0000_0000;
		end else begin
			preadyQ  <= access && !preadyQ;
			pslverrQ <= access && !preadyQ && !hit;
			if (access && !preadyQ && !pwrite) begin
				prdataQ <= hit ? rdata : 32'h0000_0000;
			end
		end
	end

	assign prdata  = prdataQ;
	assign pready  = preadyQ;
	assign pslverr = pslverrQ;

	// ****************************************
	// Configuration registers
	// ****************************************
	assign mode32  = cfgQ == CFG_32_TIMER;
	assign modeRtc = cfgQ == CFG_32_RTC;
	assign split   = cfgQ == CFG_16_SPLIT;
	assign rtcStart = wrEn && paddr == OFS_CFG && pstrb[0] && pwdata[2:0] == CFG_32_RTC && !modeRtc;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfgQ    <= CFG_32_TIMER;
			amodeQ  <= 4'h0;
			bmodeQ  <= 4'h0;
			imaskQ  <= 11'h000;
			aloadQ  <= LOAD_RESET;
			bloadQ  <= LOAD_RESET;
			amatchQ <= LOAD_RESET;
			bmatchQ <= LOAD_RESET;
			aprescQ <= PRESCALE_RESET;
			bprescQ <= PRESCALE_RESET;
		end else if (wrEn) begin
			unique case (paddr)
				OFS_CFG:    cfgQ    <= 3'(laneMerge({29'h0, cfgQ}, pwdata, pstrb));
				OFS_AMODE:  amodeQ  <= 4'(laneMerge({28'h0, amodeQ}, pwdata, pstrb));
				OFS_BMODE:  bmodeQ  <= 4'(laneMerge({28'h0, bmodeQ}, pwdata, pstrb));
				OFS_IMASK:  imaskQ  <= 11'(laneMerge({21'h0, imaskQ}, pwdata, pstrb));
				OFS_ALOAD: begin
					// In 32-bit modes the upper word lands in the second half's load
					aloadQ <= 16'(laneMerge({16'h0, aloadQ}, pwdata, pstrb));
					if (!split) begin
						bloadQ <= 16'(laneMerge({bloadQ, 16'h0}, pwdata, pstrb) >> 16);
					end
				end
				OFS_BLOAD:  bloadQ  <= 16'(laneMerge({16'h0, bloadQ}, pwdata, pstrb));
				OFS_AMATCH: begin
					amatchQ <= 16'(laneMerge({16'h0, amatchQ}, pwdata, pstrb));
					if (!split) begin
						bmatchQ <= 16'(laneMerge({bmatchQ, 16'h0}, pwdata, pstrb) >> 16);
					end
				end
				OFS_BMATCH: bmatchQ <= 16'(laneMerge({16'h0, bmatchQ}, pwdata, pstrb));
				OFS_APRESC: aprescQ <= 8'(laneMerge({24'h0, aprescQ}, pwdata, pstrb));
				OFS_BPRESC: bprescQ <= 8'(laneMerge({24'h0, bprescQ}, pwdata, pstrb));
				default: begin
				end
			endcase
		end
	end

	// Load writes take effect in the counter one cycle later
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			aLoadPulseQ <= 1'b0;
			bLoadPulseQ <= 1'b0;
			reload32Q   <= 1'b0;
		end else begin
			aLoadPulseQ <= wrEn && paddr == OFS_ALOAD && split;
			bLoadPulseQ <= wrEn && paddr == OFS_BLOAD && split;
			reload32Q   <= wrEn && paddr == OFS_ALOAD && mode32;
		end
	end

	// Hardware clears the enable of a finished one-shot
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctlQ <= 16'h0000;
		end else if (wrEn && paddr == OFS_CTL) begin
			ctlQ <= 16'(laneMerge({16'h0, ctlQ}, pwdata, pstrb));
		end else begin
			if (clrA) begin
				ctlQ[CTL_EN] <= 1'b0;
			end
			if (clrB) begin
				ctlQ[CTL_B_OFS + CTL_EN] <= 1'b0;
			end
		end
	end

	// ****************************************
	// 32-bit and real-time counter
	// ****************************************
	assign loadCat  = {bloadQ, aloadQ};
	assign matchCat = {bmatchQ, amatchQ};
	// Real-time mode ignores the stall enable
	assign run32    = mode32 && ctlQ[CTL_EN] && !(ctlQ[CTL_STALL] && debugHalt) && !reload32Q;
	assign secTick  = pinQ[0] && !rtcPrevQ && rtcDivQ == RTC_DIV_LAST;
	assign to32Evt  = run32 && cnt32Q == 32'h0000_0000;
	assign rtcEvt   = modeRtc && ctlQ[CTL_EN] && secTick && cnt32Q == matchCat && !rtcStart;
	assign clrA     = (to32Evt && amodeQ[1:0] == HALF_ONESHOT) || (split && ha.clearEnable);
	assign clrB     = split && hb.clearEnable;

	// Divider runs on rising edges of the even pin, which carries 32.768 kHz from outside
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rtcDivQ  <= 15'h0000;
			rtcPrevQ <= 1'b0;
		end else begin
			rtcPrevQ <= pinQ[0];
			if (!modeRtc || !ctlQ[CTL_EN]) begin
				rtcDivQ <= 15'h0000;
			end else if (pinQ[0] && !rtcPrevQ) begin
				rtcDivQ <= (rtcDivQ == RTC_DIV_LAST) ? 15'h0000 : rtcDivQ + 15'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt32Q <= {CNT_RESET, CNT_RESET};
		end else if (rtcStart) begin
			cnt32Q <= RTC_FIRST_LOAD;
		end else if (modeRtc) begin
			if (ctlQ[CTL_EN] && secTick) begin
				cnt32Q <= (cnt32Q == matchCat) ? 32'h0000_0000 : cnt32Q + 32'h0000_0001;
			end
		end else if (mode32) begin
			if (reload32Q) begin
				cnt32Q <= loadCat;
			end else if (run32) begin
				cnt32Q <= (cnt32Q == 32'h0000_0000) ? loadCat : cnt32Q - 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// Halves
	// ****************************************
	assign ha.enable      = split && ctlQ[CTL_EN];
	assign ha.stall       = ctlQ[CTL_STALL] && debugHalt;
	assign ha.loadWrite   = aLoadPulseQ;
	assign ha.pin         = pinQ[0];
	assign ha.pwmInvert   = ctlQ[CTL_PWMINV];
	assign ha.capTimeMode = amodeQ[MODE_CAPTIME];
	assign ha.pwmMode     = amodeQ[MODE_PWM];
	assign ha.mode        = amodeQ[1:0];
	assign ha.edgeSel     = ctlQ[CTL_EDGE +: 2];
	assign ha.loadVal     = aloadQ;
	assign ha.matchVal    = amatchQ;
	assign ha.prescale    = aprescQ;

	assign hb.enable      = split && ctlQ[CTL_B_OFS + CTL_EN];
	assign hb.stall       = ctlQ[CTL_B_OFS + CTL_STALL] && debugHalt;
	assign hb.loadWrite   = bLoadPulseQ;
	assign hb.pin         = pinQ[1];
	assign hb.pwmInvert   = ctlQ[CTL_B_OFS + CTL_PWMINV];
	assign hb.capTimeMode = bmodeQ[MODE_CAPTIME];
	assign hb.pwmMode     = bmodeQ[MODE_PWM];
	assign hb.mode        = bmodeQ[1:0];
	assign hb.edgeSel     = ctlQ[CTL_B_OFS + CTL_EDGE +: 2];
	assign hb.loadVal     = bloadQ;
	assign hb.matchVal    = bmatchQ;
	assign hb.prescale    = bprescQ;

	timer_half u_half_a (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.hb       (ha.half)
	);

	timer_half u_half_b (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.hb       (hb.half)
	);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinOutQ <= 2'b00;
			pinOeQ  <= 2'b00;
		end else begin
			pinOutQ <= {hb.pwmOut, ha.pwmOut};
			pinOeQ  <= {hb.pwmDrive && split, ha.pwmDrive && split};
		end
	end

	assign capturePinZeroOut = pinOutQ[0];
	assign capturePinZeroOe  = pinOeQ[0];
	assign capturePinOneOut  = pinOutQ[1];
	assign capturePinOneOe   = pinOeQ[1];

	// ****************************************
	// Status, interrupt and converter trigger
	// ****************************************
	always_comb begin
		setBits = 11'h000;
		setBits[ST_TIMEOUT]           = to32Evt || (split && ha.timeout);
		setBits[ST_CAPMATCH]          = split && ha.capMatch;
		setBits[ST_CAPEVENT]          = split && ha.capEvent;
		setBits[ST_RTC]               = rtcEvt;
		setBits[ST_B_OFS+ST_TIMEOUT]  = split && hb.timeout;
		setBits[ST_B_OFS+ST_CAPMATCH] = split && hb.capMatch;
		setBits[ST_B_OFS+ST_CAPEVENT] = split && hb.capEvent;
		clrBits = (wrEn && paddr == OFS_ICLEAR) ? 11'(laneMerge(32'h0, pwdata, pstrb)) : 11'h000;
	end

	// A new event outweighs a clear in the same cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rawQ <= 11'h000;
			irqQ <= 1'b0;
		end else begin
			rawQ <= (rawQ & ~clrBits) | setBits;
			irqQ <= |(((rawQ & ~clrBits) | setBits) & imaskQ);
		end
	end

	// Software must arm the trigger on one timer only; the chain cannot tell them apart
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			adcQ <= 1'b0;
		end else begin
			adcQ <= adcTriggerChainIn
				|| (ctlQ[CTL_TRIGEN] && (to32Evt || rtcEvt || (split && ha.timeout)))
				|| (ctlQ[CTL_B_OFS + CTL_TRIGEN] && split && hb.timeout);
		end
	end

	assign timerIrq   = irqQ;
	assign adcTrigger = adcQ;
endmodule

// *** dv/general_timer_monitor.sv ***
`timescale 1ns/1ns
module general_timer_monitor
	import gp_timer_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        capturePinZeroIn,
	input wire logic        capturePinZeroOut,
	input wire logic        capturePinZeroOe,
	input wire logic        capturePinOneIn,
	input wire logic        capturePinOneOut,
	input wire logic        capturePinOneOe,
	input wire logic        debugHalt,
	input wire logic        adcTriggerChainIn,
	input wire logic        adcTrigger,
	input wire logic        timerIrq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ****************************************
	// Register bus and trigger chain
	// ****************************************
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	property p_answer; s_setup ##1 s_access |-> ##1 pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_inAccess; pready |-> psel && penable; endproperty
	property p_errPair; pslverr |-> pready; endproperty
	property p_misaligned; psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
	property p_cfgOk; pready && paddr == OFS_CFG |-> !pslverr; endproperty
	// Read data only moves with a completed read
	property p_readHold; $changed(prdata) |-> pready && !pwrite; endproperty
	property p_chain; adcTriggerChainIn |=> adcTrigger; endproperty
	a_answer: assert property (p_answer) else $error("late answer");
	a_pulse: assert property (p_pulse) else $error("ready too long");
	a_inAccess: assert property (p_inAccess) else $error("ready outside access");
	a_errPair: assert property (p_errPair) else $error("error without ready");
	a_misaligned: assert property (p_misaligned) else $error("misaligned accepted");
	a_cfgOk: assert property (p_cfgOk) else $error("config refused");
	a_readHold: assert property (p_readHold) else $error("read data moved");
	a_chain: assert property (p_chain) else $error("chain not passed");
endmodule

// *** dv/pin_source.sv ***
`timescale 1ns/1ns
module pin_source (
	input  wire logic core_clk,
	input  wire logic run,
	output      logic pinLevel
);
	logic [1:0] phase = 2'h0;
	initial pinLevel = 1'b0;
	// Four cycles per level, above the synchroniser reject width
	always @(posedge core_clk) begin
		phase <= run ? phase + 2'h1 : 2'h0;
		if (!run)
			pinLevel <= 1'b0;
		else if (phase == 2'h3)
			pinLevel <= !pinLevel;
	end
endmodule

// *** dv/general_timer_module_bench.sv ***
`timescale 1ns/1ns
module general_timer_module_bench;
	import gp_timer_pkg::*;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r1, r2;
	logic        pready, pslverr, zOut, zOe, oOut, oOe, trig, irq, e, src;
	logic        run = 1'b0;
	logic        debugHalt = 1'b0;
	logic        chainIn = 1'b0;
	int          failures = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          trigSeen = 0;
	int          seed, k;
	initial forever #2 core_clk = !core_clk;
	pin_source src0 (.core_clk(core_clk), .run(run), .pinLevel(src));
	general_timer_module uut (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capturePinZeroIn(zOe ? zOut : src), .capturePinZeroOut(zOut), .capturePinZeroOe(zOe),
		.capturePinOneIn(oOe ? oOut : 1'b0), .capturePinOneOut(oOut), .capturePinOneOe(oOe),
		.debugHalt(debugHalt), .adcTriggerChainIn(chainIn), .adcTrigger(trig), .timerIrq(irq));
	always @(posedge core_clk) begin
		cycles++;
		if (trig === 1'b1)
			trigSeen++;
		if (cycles == 90000) begin
			failures++;
			conclude();
		end
	end
	task automatic conclude();
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, r1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0, r1);
		check($sformatf("reg %h", a), r1, x);
	endtask
	task automatic waitIrq(input int lim);
		for (k = 0; k < lim && irq !== 1'b1; k++)
			@(posedge core_clk);
	endtask
	task automatic highs(input logic [31:0] x);
		r2 = 0;
		// Skip the two output stages after a control write
		repeat (2) @(posedge core_clk);
		repeat (10) @(posedge core_clk) r2 += oOut;
		check("pwm high cycles", r2, x);
	endtask
	initial begin
		seed = 42471;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rd(OFS_CFG, 32'h0);
		rd(OFS_CTL, 32'h0);
		rd(OFS_APRESC, 32'h0);
		rd(OFS_ACOUNT, 32'hffffffff);
		rd(12'h010, 32'h0);
		check("unmapped error", e, 1'b1);
		rd(12'h002, 32'h0);
		check("misaligned error", e, 1'b1);
		for (int i = 0; i < 4; i++) begin
			r2 = {24'h0, 8'($random(seed))};
			wr(OFS_BPRESC, r2);
			rd(OFS_BPRESC, r2);
		end
		// Load crosses the half boundary, so a 16-bit-only counter fires early
		wr(OFS_AMODE, 32'h1);
		wr(OFS_ALOAD, 32'h00010000);
		wr(OFS_IMASK, 32'h1);
		wr(OFS_CTL, 32'h21);
		repeat (1000) @(posedge core_clk);
		check("early irq", irq, 1'b0);
		waitIrq(70000);
		// Let the trigger counter see the pulse that rose with the interrupt
		@(posedge core_clk);
		check("trigger count", trigSeen, 1);
		rd(OFS_RAWSTAT, 32'h1);
		rd(OFS_MSKSTAT, 32'h1);
		rd(OFS_CTL, 32'h20);
		wr(OFS_ICLEAR, 32'h1);
		rd(OFS_RAWSTAT, 32'h0);
		check("irq cleared", irq, 1'b0);
		wr(OFS_CFG, {29'h0, CFG_16_SPLIT});
		wr(OFS_AMODE, 32'h2);
		wr(OFS_ALOAD, 32'h100);
		wr(OFS_CTL, 32'h3);
		debugHalt <= 1'b1;
		apb(OFS_ACOUNT, 1'b0, 32'h0, r1);
		rd(OFS_ACOUNT, r1);
		debugHalt <= 1'b0;
		apb(OFS_ACOUNT, 1'b0, 32'h0, r2);
		check("runs after halt", r2 == r1, 1'b0);
		wr(OFS_CTL, 32'h0);
		wr(OFS_ICLEAR, 32'hffff);
		wr(OFS_AMODE, 32'h3);
		wr(OFS_ALOAD, 32'ha);
		wr(OFS_AMATCH, 32'h7);
		wr(OFS_IMASK, 32'h2);
		wr(OFS_CTL, 32'h1);
		run <= 1'b1;
		repeat (24) @(posedge core_clk);
		run <= 1'b0;
		repeat (10) @(posedge core_clk);
		rd(OFS_RAWSTAT, 32'h2);
		rd(OFS_CTL, 32'h0);
		check("match irq", irq, 1'b1);
		wr(OFS_BMODE, 32'ha);
		wr(OFS_BLOAD, 32'h9);
		wr(OFS_BMATCH, 32'h6);
		wr(OFS_CTL, 32'h100);
		// Drive enable passes the half's flop and the pin flop
		repeat (2) @(posedge core_clk);
		check("odd pin drive", oOe, 1'b1);
		highs(32'h3);
		wr(OFS_CTL, 32'h4100);
		highs(32'h7);
		wr(OFS_CFG, 32'h1);
		rd(OFS_ACOUNT, 32'h1);
		k = trigSeen;
		chainIn <= 1'b1;
		@(posedge core_clk);
		chainIn <= 1'b0;
		repeat (3) @(posedge core_clk);
		check("chain trigger", trigSeen, k + 1);
		conclude();
	end
endmodule
bind general_timer_module general_timer_monitor mon (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .capturePinZeroIn(capturePinZeroIn), .capturePinZeroOut(capturePinZeroOut),
	.capturePinZeroOe(capturePinZeroOe), .capturePinOneIn(capturePinOneIn), .capturePinOneOut(capturePinOneOut),
	.capturePinOneOe(capturePinOneOe), .debugHalt(debugHalt), .adcTriggerChainIn(adcTriggerChainIn),
	.adcTrigger(adcTrigger), .timerIrq(timerIrq));
